// file: verilog/can_fd_protocol_mode_control.sv
// Operation mode, restricted mode, clock stop and frame format control of a CAN FD controller.
// Assumes a bit engine on sys_clk that gives frame events as pulses and busy levels.
`timescale 1ns/10ps
`default_nettype none
module can_fd_protocol_mode_control
  import can_mode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output wire logic irq,
  input wire logic rx_busy,
  input wire logic tx_busy,
  input wire logic sample_pt,
  input wire logic rx_ctl_valid,
  input wire logic rx_fdf,
  input wire logic rx_res,
  input wire logic rx_arb_valid,
  input wire logic rx_ext,
  input wire logic [ID_W-1:0] rx_id,
  input wire logic rx_frame_done,
  input wire logic tx_start,
  input wire logic tx_ext,
  input wire logic [ID_W-1:0] tx_id,
  input wire logic tx_fd_req,
  input wire logic tx_brs_req,
  input wire logic tx_done,
  input wire logic [BUF_W-1:0] tx_buf,
  input wire logic ram_fail,
  output logic tx_request,
  output logic tx_go,
  output logic tx_abort,
  output logic tx_fdf_bit,
  output logic tx_fd_format,
  output logic tx_dlc_corrupt,
  output logic tx_bad_format,
  output logic tx_unexpected_hdr,
  output logic rec_edl,
  output logic rec_brs,
  output logic rx_discard,
  output logic [ID_W-1:0] rx_id_out,
  output wire logic tq_tick,
  output wire logic seg2_done
);
  logic init_r;
  logic cce_r;
  logic asm_r;
  logic csa_r;
  logic csr_r;
  logic fd_r;
  logic brs_r;
  logic [MODE_W-1:0] cme_r;
  logic [MODE_W-1:0] cmr_r;
  logic [SEG_W-1:0] seg2_r;
  logic [PRE_W-1:0] pre_r;
  logic [NBUF-1:0] pend_r;
  logic pex_arm_r;
  logic haz_r;
  logic hdr_arm_r;
  logic init_rx_r;
  logic [1:0] stops_r;
  cs_state_t cs_r;
  cs_state_t cs_nxt;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] istat;
  logic [IRQ_W-1:0] imask;
  logic [DATA_W-1:0] rd_nxt;
  logic [NBUF-1:0] done_mask;

  wire ctrl_wr = reg_wr && (reg_addr == A_CTRL);
  wire btim_wr = reg_wr && (reg_addr == A_BTIM);
  wire istat_wr = reg_wr && (reg_addr == A_ISTAT);
  wire imask_wr = reg_wr && (reg_addr == A_IMASK);
  wire txadd_wr = reg_wr && (reg_addr == A_TXADD);
  wire txcan_wr = reg_wr && (reg_addr == A_TXCAN);
  wire [MODE_W-1:0] new_cmr = reg_wdata[B_CMR +: MODE_W];
  wire fd_enabled = (cme_r != CME_OFF);

  // Timing of zero in both fields is legal but corrupts the FDF or reserved bit on transmit.
  wire both_zero = (seg2_r == '0) && (pre_r == '0);
  wire fd_frame = fd_r && tx_fd_req && fd_enabled;
  wire id28 = tx_id[ID_W-1];

  // A mode request written in the very cycle a transmission starts races the start.
  wire mode_race = tx_start && ctrl_wr && (new_cmr != MODE_NONE) && fd_enabled;
  wire fall_back = mode_race && fd_r && (new_cmr == MODE_CLASSIC);
  wire tx_allowed = !asm_r && !init_r;
  wire launch = tx_start && tx_allowed && !fall_back;
  wire stop_ack = (cs_r == CS_WAIT) && csr_r && !rx_busy && !tx_busy;
  wire hw_restrict = ram_fail || fall_back;
  wire pex_event = rx_ctl_valid && rx_fdf && rx_res;
  wire asm_clr = ctrl_wr && cce_r && asm_r && !reg_wdata[B_ASM] && !hw_restrict;
  wire tail_dom = rx_ext ? (rx_id[TAIL_EXT-1:0] == '0) : (rx_id[TAIL_STD-1:0] == '0);

  // Clock stop handshake waits for the bus engine to go idle before acknowledging.
  always_comb begin
    cs_nxt = cs_r;
    case (cs_r)
      CS_RUN: begin
        if (csr_r) begin
          cs_nxt = CS_WAIT;
        end
      end
      CS_WAIT: begin
        if (!csr_r) begin
          cs_nxt = CS_RUN;
        end else if (stop_ack) begin
          cs_nxt = CS_ACK;
        end
      end
      CS_ACK: begin
        if (!csr_r) begin
          cs_nxt = CS_RUN;
        end
      end
      default: begin
        cs_nxt = CS_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cs_r <= CS_RUN;
      csa_r <= 1'b0;
    end else begin
      cs_r <= cs_nxt;
      csa_r <= (cs_nxt == CS_ACK);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      csr_r <= 1'b0;
    end else if (ctrl_wr) begin
      csr_r <= reg_wdata[B_CSR];
    end
  end

  // The acknowledge sets init even against a host write clearing it in the same cycle.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      init_r <= INIT_RST;
    end else if (stop_ack) begin
      init_r <= 1'b1;
    end else if (ctrl_wr) begin
      init_r <= reg_wdata[B_INIT];
    end
  end

  // Init raised during reception leaves a stale state that flags the first later frame.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      init_rx_r <= 1'b0;
    end else if (ctrl_wr && reg_wdata[B_INIT] && !init_r && rx_busy) begin
      init_rx_r <= 1'b1;
    end else if (rx_frame_done && !init_r) begin
      init_rx_r <= 1'b0;
    end
  end

  // Configuration change is only possible while init is set and drops with it.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cce_r <= 1'b0;
    end else if (!init_r) begin
      cce_r <= 1'b0;
    end else if (ctrl_wr) begin
      cce_r <= reg_wdata[B_CCE];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      asm_r <= 1'b0;
    end else if (hw_restrict) begin
      asm_r <= 1'b1;
    end else if (ctrl_wr && cce_r) begin
      asm_r <= reg_wdata[B_ASM];
    end
  end

  // The header hazard left by a failure is flushed by two clock stop acknowledges.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      haz_r <= 1'b0;
      stops_r <= '0;
    end else if (hw_restrict) begin
      haz_r <= 1'b1;
      stops_r <= '0;
    end else if (haz_r && stop_ack) begin
      if (stops_r + 1'b1 == STOPS_CLR) begin
        haz_r <= 1'b0;
      end
      stops_r <= stops_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hdr_arm_r <= 1'b0;
    end else if (asm_clr && haz_r) begin
      hdr_arm_r <= 1'b1;
    end else if (launch) begin
      hdr_arm_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cme_r <= CME_OFF;
      seg2_r <= SEG2_RST;
      pre_r <= PRE_RST;
    end else begin
      if (ctrl_wr && cce_r) begin
        cme_r <= reg_wdata[B_CME +: MODE_W];
      end
      if (btim_wr && cce_r) begin
        seg2_r <= reg_wdata[B_SEG2 +: SEG_W];
        pre_r <= reg_wdata[B_PRE +: PRE_W];
      end
    end
  end

  // A mode request is applied one cycle after the write and then reads back as none.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cmr_r <= MODE_NONE;
      fd_r <= 1'b0;
      brs_r <= 1'b0;
    end else if (!fd_enabled) begin
      cmr_r <= MODE_NONE;
      fd_r <= 1'b0;
      brs_r <= 1'b0;
    end else if (ctrl_wr && (new_cmr != MODE_NONE)) begin
      cmr_r <= new_cmr;
    end else if (cmr_r != MODE_NONE) begin
      cmr_r <= MODE_NONE;
      fd_r <= (cmr_r != MODE_CLASSIC);
      brs_r <= (cmr_r == MODE_FDBRS);
    end
  end

  // The first message after an exception, sent or received, consumes the stale state.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pex_arm_r <= 1'b0;
    end else if (pex_event) begin
      pex_arm_r <= 1'b1;
    end else if (rx_frame_done || launch) begin
      pex_arm_r <= 1'b0;
    end
  end

  always_comb begin
    done_mask = '0;
    if (tx_done) begin
      done_mask = NBUF'(1) << tx_buf;
    end
  end

  // Adding a buffer wins over a completion of the same buffer in one cycle.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~done_mask & ~(txcan_wr ? reg_wdata : '0)) | (txadd_wr ? reg_wdata : '0);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_request <= 1'b0;
      tx_go <= 1'b0;
      tx_abort <= 1'b0;
    end else begin
      tx_request <= (pend_r != '0) && tx_allowed;
      tx_go <= launch;
      tx_abort <= tx_start && !launch;
    end
  end

  // Format outputs hold from one launch to the next.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_fdf_bit <= 1'b0;
      tx_fd_format <= 1'b0;
      tx_dlc_corrupt <= 1'b0;
      tx_bad_format <= 1'b0;
      tx_unexpected_hdr <= 1'b0;
    end else if (launch) begin
      tx_bad_format <= pex_arm_r;
      tx_unexpected_hdr <= hdr_arm_r;
      if (fd_frame && both_zero && (!tx_ext || !id28)) begin
        tx_fdf_bit <= 1'b0;
        tx_fd_format <= 1'b0;
        tx_dlc_corrupt <= 1'b1;
      end else if (fd_frame) begin
        tx_fdf_bit <= 1'b1;
        tx_fd_format <= 1'b1;
        tx_dlc_corrupt <= 1'b0;
      end else begin
        tx_fdf_bit <= both_zero && tx_ext && id28;
        tx_fd_format <= 1'b0;
        tx_dlc_corrupt <= 1'b0;
      end
    end
  end

  // On a race the record follows the newly written mode, the frame the old one.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rec_edl <= 1'b0;
      rec_brs <= 1'b0;
    end else if (launch && mode_race) begin
      rec_edl <= tx_fd_req && (new_cmr != MODE_CLASSIC);
      rec_brs <= tx_fd_req && tx_brs_req && (new_cmr == MODE_FDBRS);
    end else if (launch) begin
      rec_edl <= fd_frame;
      rec_brs <= fd_frame && brs_r && tx_brs_req;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_discard <= 1'b0;
      rx_id_out <= '0;
    end else begin
      rx_discard <= pex_event;
      if (rx_arb_valid) begin
        rx_id_out <= (tail_dom && fd_enabled && (pend_r != '0)) ? tx_id : rx_id;
      end
    end
  end

  always_comb begin
    ev = '0;
    ev[I_MRAF] = hw_restrict || (rx_frame_done && pex_arm_r) || (rx_frame_done && init_rx_r && !init_r);
    ev[I_PEX] = pex_event;
    ev[I_ABORT] = tx_start && !launch;
  end

  always_comb begin
    rd_nxt = '0;
    case (reg_addr)
      A_CTRL: begin
        rd_nxt[B_INIT] = init_r;
        rd_nxt[B_CCE] = cce_r;
        rd_nxt[B_ASM] = asm_r;
        rd_nxt[B_CSA] = csa_r;
        rd_nxt[B_CSR] = csr_r;
        rd_nxt[B_CME +: MODE_W] = cme_r;
        rd_nxt[B_CMR +: MODE_W] = cmr_r;
        rd_nxt[B_FDO] = fd_r;
        rd_nxt[B_FDBS] = brs_r;
      end
      A_BTIM: begin
        rd_nxt[B_SEG2 +: SEG_W] = seg2_r;
        rd_nxt[B_PRE +: PRE_W] = pre_r;
      end
      A_ISTAT: rd_nxt[IRQ_W-1:0] = istat;
      A_IMASK: rd_nxt[IRQ_W-1:0] = imask;
      A_TXPEND: rd_nxt = pend_r;
      A_STAT: begin
        rd_nxt[S_PEX] = pex_arm_r;
        rd_nxt[S_HAZ] = haz_r;
        rd_nxt[S_HDR] = hdr_arm_r;
        rd_nxt[S_INITRX] = init_rx_r;
        rd_nxt[S_STOPS +: 2] = stops_r;
      end
      default: rd_nxt = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= '0;
    end
  end

  irq_unit u_irq (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .set_ev(ev),
    .clr_wr(istat_wr),
    .mask_wr(imask_wr),
    .wdata(reg_wdata[IRQ_W-1:0]),
    .status(istat),
    .mask(imask),
    .irq(irq)
  );

  tq_timer u_tq (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .prescale(pre_r),
    .phase_len(seg2_r),
    .sample_pt(sample_pt),
    .tq_tick(tq_tick),
    .seg2_done(seg2_done)
  );
endmodule
`default_nettype wire

// file: inc/can_mode_pkg.sv
// Constants, register map and state encodings of the CAN FD mode control block.
// Assumes one sys_clk domain and the plain register port of the top module.
package can_mode_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int ID_W = 29;
  localparam int BUF_W = 5;
  localparam int NBUF = 32;
  localparam int PRE_W = 9;
  localparam int SEG_W = 7;
  localparam int IRQ_W = 3;
  localparam int MODE_W = 2;

  localparam logic [ADDR_W-1:0] A_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] A_BTIM = 5'h04;
  localparam logic [ADDR_W-1:0] A_ISTAT = 5'h08;
  localparam logic [ADDR_W-1:0] A_IMASK = 5'h0c;
  localparam logic [ADDR_W-1:0] A_TXADD = 5'h10;
  localparam logic [ADDR_W-1:0] A_TXCAN = 5'h14;
  localparam logic [ADDR_W-1:0] A_TXPEND = 5'h18;
  localparam logic [ADDR_W-1:0] A_STAT = 5'h1c;

  localparam int B_INIT = 0;
  localparam int B_CCE = 1;
  localparam int B_ASM = 2;
  localparam int B_CSA = 3;
  localparam int B_CSR = 4;
  localparam int B_CME = 8;
  localparam int B_CMR = 10;
  localparam int B_FDO = 12;
  localparam int B_FDBS = 13;

  localparam int B_SEG2 = 0;
  localparam int B_PRE = 16;
  localparam logic [SEG_W-1:0] SEG2_RST = 7'h03;
  localparam logic [PRE_W-1:0] PRE_RST = 9'h000;

  localparam int I_MRAF = 0;
  localparam int I_PEX = 1;
  localparam int I_ABORT = 2;

  localparam int S_PEX = 0;
  localparam int S_HAZ = 1;
  localparam int S_HDR = 2;
  localparam int S_INITRX = 3;
  localparam int S_STOPS = 4;

  localparam logic [MODE_W-1:0] MODE_NONE = 2'h0;
  localparam logic [MODE_W-1:0] MODE_FD = 2'h1;
  localparam logic [MODE_W-1:0] MODE_FDBRS = 2'h2;
  localparam logic [MODE_W-1:0] MODE_CLASSIC = 2'h3;
  localparam logic [MODE_W-1:0] CME_OFF = 2'h0;
  localparam logic INIT_RST = 1'b1;

  localparam int TAIL_STD = 2;
  localparam int TAIL_EXT = 3;
  localparam logic [1:0] STOPS_CLR = 2'h2;

  typedef enum logic [2:0] {
    CS_RUN = 3'b001,
    CS_WAIT = 3'b010,
    CS_ACK = 3'b100
  } cs_state_t;
endpackage

// file: verilog/tq_timer.sv
// Time quantum prescaler and phase segment timer after the sample point.
// Assumes sample_pt is a one-cycle pulse from the bit engine on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module tq_timer
  import can_mode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [PRE_W-1:0] prescale,
  input wire logic [SEG_W-1:0] phase_len,
  input wire logic sample_pt,
  output logic tq_tick,
  output logic seg2_done
);
  logic [PRE_W-1:0] pre_cnt_r;
  logic [SEG_W-1:0] seg_cnt_r;
  logic seg_run_r;
  logic quantum_end;

  // A compare with >= keeps the counter from running away if the prescaler is lowered mid-count.
  assign quantum_end = (pre_cnt_r >= prescale);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pre_cnt_r <= '0;
    end else if (sample_pt || quantum_end) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      seg_cnt_r <= '0;
      seg_run_r <= 1'b0;
      seg2_done <= 1'b0;
      tq_tick <= 1'b0;
    end else begin
      tq_tick <= quantum_end;
      seg2_done <= seg_run_r && quantum_end && (seg_cnt_r == '0) && !sample_pt;
      if (sample_pt) begin
        seg_cnt_r <= phase_len;
        seg_run_r <= 1'b1;
      end else if (seg_run_r && quantum_end) begin
        if (seg_cnt_r == '0) begin
          seg_run_r <= 1'b0;
        end else begin
          seg_cnt_r <= seg_cnt_r - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/irq_unit.sv
// Sticky interrupt status with write-one-to-clear, a mask and one level output.
// Assumes set_ev pulses and the write strobes come from logic on sys_clk.
`timescale 1ns/10ps
`default_nettype none
module irq_unit
  import can_mode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [IRQ_W-1:0] set_ev,
  input wire logic clr_wr,
  input wire logic mask_wr,
  input wire logic [IRQ_W-1:0] wdata,
  output logic [IRQ_W-1:0] status,
  output logic [IRQ_W-1:0] mask,
  output logic irq
);
  logic [IRQ_W-1:0] status_nxt;
  logic [IRQ_W-1:0] mask_nxt;

  // An event in the same cycle as its clear stays set.
  always_comb begin
    status_nxt = (status & ~(clr_wr ? wdata : '0)) | set_ev;
    mask_nxt = mask_wr ? wdata : mask;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status <= '0;
      mask <= '0;
      irq <= 1'b0;
    end else begin
      status <= status_nxt;
      mask <= mask_nxt;
      irq <= |(status_nxt & mask_nxt);
    end
  end
endmodule
`default_nettype wire

// file: bench/can_mode_chk_sva.sv
// Checker for the frame start, format and receive outputs of the mode control block.
// Assumes it is bound into the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module can_mode_chk
  import can_mode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic rx_ctl_valid,
  input wire logic rx_fdf,
  input wire logic rx_res,
  input wire logic rx_discard,
  input wire logic tx_start,
  input wire logic tx_go,
  input wire logic tx_abort,
  input wire logic tx_fdf_bit,
  input wire logic tx_fd_format,
  input wire logic tx_dlc_corrupt,
  input wire logic rx_arb_valid,
  input wire logic rx_ext,
  input wire logic [ID_W-1:0] rx_id,
  input wire logic [ID_W-1:0] rx_id_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire exc = rx_ctl_valid & rx_fdf & rx_res;
  wire [2:0] fmt = {tx_fdf_bit, tx_fd_format, tx_dlc_corrupt};
  a_exc_discard: assert property (exc |=> rx_discard)
    else $error("no discard after exception");
  a_discard_cause: assert property (rx_discard |-> $past(exc))
    else $error("discard without exception");
  a_start_answer: assert property (tx_start |=> tx_go != tx_abort)
    else $error("start not answered once");
  a_answer_cause: assert property ((tx_go || tx_abort) |-> $past(tx_start))
    else $error("answer without start");
  a_corrupt_fmt: assert property (tx_dlc_corrupt |-> !tx_fdf_bit && !tx_fd_format)
    else $error("corrupt frame flags wrong");
  a_fd_fdf: assert property (tx_fd_format |-> tx_fdf_bit)
    else $error("fd frame without fdf");
  a_fmt_hold: assert property (!tx_go |-> $stable(fmt))
    else $error("format moved without start");
  a_id_hold: assert property (!$past(rx_arb_valid) |-> $stable(rx_id_out))
    else $error("id moved without arbitration");
  a_id_copy: assert property (rx_arb_valid && !rx_ext && rx_id[1:0] != 2'h0 |=> rx_id_out == $past(rx_id))
    else $error("received id not passed");
  c_discard: cover property (rx_discard);
  c_abort: cover property (tx_abort);
  c_corrupt: cover property (tx_go && tx_dlc_corrupt);
endmodule
bind can_fd_protocol_mode_control can_mode_chk u_can_mode_chk (.sys_clk, .rstn, .rx_ctl_valid, .rx_fdf,
  .rx_res, .rx_discard, .tx_start, .tx_go, .tx_abort, .tx_fdf_bit, .tx_fd_format, .tx_dlc_corrupt,
  .rx_arb_valid, .rx_ext, .rx_id, .rx_id_out);
`default_nettype wire

// file: bench/can_engine_model.sv
// Bit engine and bus side model: frame events as one-cycle pulses with their qualifiers.
// Assumes the bench calls its tasks; released qualifiers show inverted values, never the last ones.
`timescale 1ns/10ps
`default_nettype none
module can_engine_model (
  input wire logic sys_clk,
  output logic rx_busy,
  output logic tx_busy,
  output logic sample_pt,
  output logic rx_ctl_valid,
  output logic rx_fdf,
  output logic rx_res,
  output logic rx_arb_valid,
  output logic rx_ext,
  output logic [28:0] rx_id,
  output logic rx_frame_done,
  output logic tx_start,
  output logic tx_ext,
  output logic [28:0] tx_id,
  output logic tx_fd_req,
  output logic tx_brs_req,
  output logic tx_done,
  output logic [4:0] tx_buf,
  output logic ram_fail
);
  initial begin
    {rx_busy, tx_busy, sample_pt, rx_ctl_valid, rx_fdf, rx_res, rx_arb_valid, rx_ext, rx_id} = '0;
    {rx_frame_done, tx_start, tx_ext, tx_id, tx_fd_req, tx_brs_req, tx_done, tx_buf, ram_fail} = '0;
  end
  task automatic start(input logic fd, rate_switch_flag, ext, input logic [28:0] id);
    @(posedge sys_clk);
    {tx_start, tx_fd_req, tx_brs_req, tx_ext, tx_id} <= {1'b1, fd, rate_switch_flag, ext, id};
    @(posedge sys_clk);
    {tx_start, tx_fd_req, tx_brs_req, tx_ext, tx_id} <= {1'b0, ~fd, ~rate_switch_flag, ~ext, ~id};
  endtask
  task automatic rx(input logic c, a, f, r, e, input logic [28:0] id);
    @(posedge sys_clk);
    {rx_ctl_valid, rx_arb_valid, rx_fdf, rx_res, rx_ext, rx_id} <= {c, a, f, r, e, id};
    @(posedge sys_clk);
    {rx_ctl_valid, rx_arb_valid, rx_fdf, rx_res, rx_ext, rx_id} <= {2'b00, ~f, ~r, ~e, ~id};
  endtask
  // Event order in v: sample point, frame stored, RAM failure, transmit done.
  task automatic ev(input logic [3:0] v, input logic [4:0] b);
    @(posedge sys_clk);
    {sample_pt, rx_frame_done, ram_fail, tx_done, tx_buf} <= {v, b};
    @(posedge sys_clk);
    {sample_pt, rx_frame_done, ram_fail, tx_done, tx_buf} <= {4'h0, ~b};
  endtask
  task automatic busy(input logic b);
    @(posedge sys_clk);
    rx_busy <= b;
  endtask
endmodule
`default_nettype wire

// file: bench/test_can_fd_protocol_mode_control.sv
// Self-checking testbench of the CAN FD mode control block; the bench acts as host.
// Assumes the engine model drives the frame side and the checker is bound in.
`timescale 1ns/10ps
`default_nettype none
module test_can_fd_protocol_mode_control
  import can_mode_pkg::*;
();
  logic sys_clk, rstn, reg_wr, reg_rd, irq, tx_request, tx_go, tx_abort, tx_fdf_bit, tx_fd_format, tq_tick;
  logic tx_dlc_corrupt, tx_bad_format, tx_unexpected_hdr, rec_edl, rec_brs, rx_discard, seg2_done;
  logic rx_busy, tx_busy, sample_pt, rx_ctl_valid, rx_fdf, rx_res, rx_arb_valid, rx_ext, rx_frame_done;
  logic tx_start, tx_ext, tx_fd_req, tx_brs_req, tx_done, ram_fail;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic [ID_W-1:0] rx_id, tx_id, rx_id_out, id;
  logic [BUF_W-1:0] tx_buf;
  int n_fail, n_tests, k, j;
  can_fd_protocol_mode_control u_can_fd_protocol_mode_control (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq, .rx_busy, .tx_busy, .sample_pt, .rx_ctl_valid, .rx_fdf, .rx_res, .rx_arb_valid,
    .rx_ext, .rx_id, .rx_frame_done, .tx_start, .tx_ext, .tx_id, .tx_fd_req, .tx_brs_req, .tx_done, .tx_buf,
    .ram_fail, .tx_request, .tx_go, .tx_abort, .tx_fdf_bit, .tx_fd_format, .tx_dlc_corrupt, .tx_bad_format,
    .tx_unexpected_hdr, .rec_edl, .rec_brs, .rx_discard, .rx_id_out, .tq_tick, .seg2_done);
  can_engine_model u_can_engine_model (.sys_clk, .rx_busy, .tx_busy, .sample_pt, .rx_ctl_valid, .rx_fdf, .rx_res,
    .rx_arb_valid, .rx_ext, .rx_id, .rx_frame_done, .tx_start, .tx_ext, .tx_id, .tx_fd_req, .tx_brs_req, .tx_done,
    .tx_buf, .ram_fail);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic reset_dut;
    rstn <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask
  // Config change must be on before FD operation is enabled, and FD operation before a mode request counts.
  task automatic setup(input logic [DATA_W-1:0] bt);
    wr(A_CTRL, 32'h103);
    wr(A_BTIM, bt);
    wr(A_CTRL, 32'h103);
    wr(A_CTRL, 32'h500);
  endtask
  // Reference: {go, fdf, fd format, dlc corrupt, edl} for one accepted start.
  function automatic logic [4:0] fmt_model(input logic fd, ext, bz, input logic [28:0] i);
    if (fd && bz && (!ext || !i[28])) return 5'b10011;
    if (fd) return 5'b11101;
    return {1'b1, bz & ext & i[28], 3'b000};
  endfunction
  task automatic sweep(input logic bz);
    for (int i = 0; i < 8; i++) begin
      id = i[1] ? {i[2], 28'($urandom)} : {18'h0, 11'($urandom)};
      u_can_engine_model.start(i[0], 1'b0, i[1], id);
      #1 chk({tx_go, tx_fdf_bit, tx_fd_format, tx_dlc_corrupt, rec_edl}, fmt_model(i[0], i[1], bz, id));
    end
  endtask
  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, n_fail, n_tests} = '0;
    k = $urandom(29);
    reset_dut();
    rd(A_CTRL, d);
    chk(d, 32'h1);
    rd(A_BTIM, d);
    chk(d, 32'h3);
    rd(5'h02, d);
    chk(d, 32'h0);
    // Both-zero timing with FD is used on purpose here, against the host restriction.
    setup(32'h0);
    rd(A_BTIM, d);
    chk(d, 32'h0);
    rd(A_CTRL, d);
    chk(d, 32'h1100);
    u_can_engine_model.ev(4'h8, 5'h0);
    j = 0;
    for (k = 1; k <= 4; k++) begin
      @(posedge sys_clk);
      #1;
      if (seg2_done === 1'b1 && j == 0) j = k;
      chk(tq_tick, 1'b1);
    end
    chk(j, 1);
    sweep(1'b1);
    wr(A_IMASK, 32'h2);
    u_can_engine_model.rx(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 29'h0);
    #1 chk({rx_discard, irq}, 2'b00);
    u_can_engine_model.rx(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 29'h0);
    #1 chk({rx_discard, irq}, 2'b11);
    u_can_engine_model.ev(4'h4, 5'h0);
    rd(A_ISTAT, d);
    chk(d, 32'h3);
    wr(A_ISTAT, 32'h2);
    rd(A_ISTAT, d);
    chk({d[30:0], irq}, {31'h1, 1'b0});
    wr(A_ISTAT, 32'h7);
    u_can_engine_model.rx(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 29'h0);
    for (k = 0; k < 2; k++) begin
      u_can_engine_model.start(1'b0, 1'b0, 1'b0, 29'h123);
      #1 chk({tx_go, tx_bad_format}, {1'b1, k == 0});
    end
    rd(A_ISTAT, d);
    chk(d, 32'h2);
    reset_dut();
    setup(32'h3);
    sweep(1'b0);
    fork
      wr(A_CTRL, 32'h900);
      u_can_engine_model.start(1'b1, 1'b1, 1'b1, {1'b1, 28'($urandom)});
    join
    #1 chk({tx_go, tx_fdf_bit, tx_fd_format, rec_edl, rec_brs}, 5'b11111);
    fork
      wr(A_CTRL, 32'hd00);
      u_can_engine_model.start(1'b1, 1'b0, 1'b0, 29'h55);
    join
    #1 chk({tx_go, tx_abort}, 2'b01);
    rd(A_ISTAT, d);
    chk(d & 32'h5, 32'h5);
    rd(A_CTRL, d);
    chk(d & 32'h4, 32'h4);
    wr(A_CTRL, 32'h105);
    wr(A_CTRL, 32'h107);
    wr(A_CTRL, 32'h103);
    rd(A_STAT, d);
    chk(d & 32'h4, 32'h4);
    wr(A_CTRL, 32'h100);
    u_can_engine_model.start(1'b0, 1'b0, 1'b0, 29'h2a);
    #1 chk({tx_go, tx_unexpected_hdr}, 2'b11);
    reset_dut();
    setup(32'h3);
    wr(A_TXADD, 32'h3);
    @(posedge sys_clk);
    #1 chk(tx_request, 1'b1);
    u_can_engine_model.ev(4'h2, 5'h0);
    rd(A_CTRL, d);
    chk(d & 32'h4, 32'h4);
    rd(A_ISTAT, d);
    chk(d, 32'h1);
    u_can_engine_model.start(1'b0, 1'b0, 1'b0, 29'h7);
    #1 chk({tx_go, tx_abort}, 2'b01);
    rd(A_TXPEND, d);
    chk({d[30:0], tx_request}, {31'h3, 1'b0});
    wr(A_TXCAN, 32'hffffffff);
    rd(A_TXPEND, d);
    chk(d, 32'h0);
    wr(A_TXADD, 32'h1);
    for (k = 0; k < 4; k++) begin
      id = (k == 2) ? 29'h1234560 : {18'h0, 11'h7fc | 11'(k == 1)};
      if (k == 3) u_can_engine_model.ev(4'h1, 5'h0);
      u_can_engine_model.rx(1'b0, 1'b1, 1'b0, 1'b0, k == 2, id);
      #1 chk(rx_id_out, (k == 0 || k == 2) ? tx_id : id);
    end
    wr(A_ISTAT, 32'h7);
    u_can_engine_model.busy(1'b1);
    wr(A_CTRL, 32'h101);
    u_can_engine_model.busy(1'b0);
    wr(A_CTRL, 32'h100);
    u_can_engine_model.ev(4'h4, 5'h0);
    rd(A_ISTAT, d);
    chk(d & 32'h1, 32'h1);
    u_can_engine_model.busy(1'b1);
    wr(A_CTRL, 32'h110);
    repeat (3) @(posedge sys_clk);
    rd(A_CTRL, d);
    chk(d & 32'h8, 32'h0);
    u_can_engine_model.busy(1'b0);
    for (k = 0; k < 8 && (d & 32'h9) != 32'h9; k++) rd(A_CTRL, d);
    if ((d & 32'h9) != 32'h9) begin
      n_fail++;
      final_report();
    end
    chk(d & 32'h19, 32'h19);
    wr(A_CTRL, 32'h100);
    wr(A_CTRL, 32'h111);
    repeat (2) @(posedge sys_clk);
    wr(A_CTRL, 32'h103);
    rd(A_STAT, d);
    chk(d, 32'h20);
    wr(A_CTRL, 32'h103);
    wr(A_CTRL, 32'h500);
    u_can_engine_model.start(1'b0, 1'b0, 1'b0, 29'h2a);
    #1 chk({tx_go, tx_unexpected_hdr}, 2'b10);
    final_report();
  end
endmodule
`default_nettype wire
